/* File: shared/cips_pkg.sv */
// Constants and the routing function shared by the capture input pin select block.
//
// Overview of operation
// - Register one holds capture 2 select in bits 12:8, capture 1 in 4:0.
// - Register two holds capture 8 select in bits 12:8, capture 7 in 4:0.
// - Select codes zero to twenty-five route that numbered remappable pin to the capture input.
// - An all-ones select code holds the capture input at constant low.
package cips_pkg;

  // Bus geometry: byte addresses, one aligned 32-bit word per register.
  localparam int unsigned ADDR_W    = 4;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned BE_W      = 4;
  localparam logic [3:0]  OFS_SEL12 = 4'h0;
  localparam logic [3:0]  OFS_SEL78 = 4'h4;

  // Select field layout inside each 16-bit register.
  localparam int unsigned SEL_W     = 5;
  localparam int unsigned LO_LSB    = 0;
  localparam int unsigned HI_LSB    = 8;
  localparam int unsigned REG_W     = 16;

  // Pin side and code values.
  localparam int unsigned PIN_N     = 26;
  localparam logic [4:0]  MAX_PIN   = 5'h19;
  localparam logic [4:0]  TIE_LOW   = 5'h1F;
  localparam logic [4:0]  SEL_RST   = 5'h1F;

  // Routes one capture input from its select code.
  function automatic logic route_pin(input logic [4:0] code, input logic [PIN_N-1:0] pins);
    logic res;
    res = 1'b0;
    if (code <= MAX_PIN)
    begin
      res = pins[code];
    end
    return res;
  endfunction : route_pin

endpackage : cips_pkg

/* File: hdl/cips_route_mux.sv */
// One capture input route: selected pin sampled into a flip-flop.
`timescale 1ns/1ps
module cips_route_mux (
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  input  wire logic [4:0]                 sel,
  input  wire logic [cips_pkg::PIN_N-1:0] remappable_pin,
  output logic                            capture_in
);

  // Registered so the capture input never glitches while software changes the select.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      capture_in <= 1'b0;
    end
    else
    begin
      capture_in <= cips_pkg::route_pin(sel, remappable_pin);
    end
  end

endmodule : cips_route_mux

/* File: hdl/cips_avalon_slave.sv */
// Avalon-MM handshake for the pin select registers: one wait cycle per access.
`timescale 1ns/1ps
module cips_avalon_slave (
  input  wire logic                         mclk,
  input  wire logic                         rst_n,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [cips_pkg::DATA_W-1:0]  rd_value,
  output logic                              wr_commit,
  output logic                              avs_waitrequest,
  output logic [cips_pkg::DATA_W-1:0]       avs_readdata
);

  typedef enum logic [1:0] {
    CIPS_IDLE = 2'b01,
    CIPS_ACK  = 2'b10
  } cips_state_type;

  cips_state_type state_ff;
  cips_state_type nxt_state;

  // A request first sees waitrequest high; read data is latched on the same edge that drops waitrequest.
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      CIPS_IDLE:
      begin
        if (avs_read || avs_write)
        begin
          nxt_state = CIPS_ACK;
        end
      end
      CIPS_ACK:
      begin
        nxt_state = CIPS_IDLE;
      end
      default:
      begin
        nxt_state = CIPS_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= CIPS_IDLE;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Waitrequest comes from a flip-flop and is low for exactly the completing cycle.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      avs_waitrequest <= !(state_ff == CIPS_IDLE && (avs_read || avs_write));
    end
  end

  // Read data is captured with the drop of waitrequest and held until the next read.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      avs_readdata <= '0;
    end
    else if (state_ff == CIPS_IDLE && avs_read)
    begin
      avs_readdata <= rd_value;
    end
  end

  // The write lands on the same edge at which the master sees waitrequest low.
  assign wr_commit = (state_ff == CIPS_ACK) && avs_write;

endmodule : cips_avalon_slave

/* File: hdl/cips_top.sv */
// Capture input pin select: two select registers and four routed capture inputs.
//
// Local design decisions: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module cips_top (
  input  wire logic                         mclk,
  input  wire logic                         rst_n,
  input  wire logic [cips_pkg::ADDR_W-1:0]  avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [cips_pkg::DATA_W-1:0]  avs_writedata,
  input  wire logic [cips_pkg::BE_W-1:0]    avs_byteenable,
  output logic                              avs_waitrequest,
  output logic [cips_pkg::DATA_W-1:0]       avs_readdata,
  input  wire logic [cips_pkg::PIN_N-1:0]   remappable_pin,
  output logic                              capture_input_one,
  output logic                              capture_input_two,
  output logic                              capture_input_seven,
  output logic                              capture_input_eight
);

  logic [4:0]                   capture1_pin_sel_ff;
  logic [4:0]                   capture2_pin_sel_ff;
  logic [4:0]                   capture7_pin_sel_ff;
  logic [4:0]                   capture8_pin_sel_ff;
  logic [cips_pkg::DATA_W-1:0]  rd_value;
  logic                         wr_commit;
  logic                         wr_sel12;
  logic                         wr_sel78;
  logic [1:0]                   reg_hit;

  // Both readback and the write strobes decode through this one function, so they can
  // never disagree about the register map. Bit 0 names the capture one/two register,
  // and bit 1 names the capture seven/eight register.
  function automatic logic [1:0] decode_reg(input logic [cips_pkg::ADDR_W-1:0] adr);
    logic [1:0] hit;
    hit = 2'h0;
    if (adr == cips_pkg::OFS_SEL12)
    begin
      hit = 2'h1;
    end
    else if (adr == cips_pkg::OFS_SEL78)
    begin
      hit = 2'h2;
    end
    return hit;
  endfunction : decode_reg

  // Register hit for the current bus address.
  assign reg_hit = decode_reg(avs_address);

  // Readback: fields in place, every other bit zero, unmapped addresses read zero.
  always_comb
  begin
    rd_value = '0;
    if (reg_hit[0])
    begin
      rd_value[cips_pkg::LO_LSB +: cips_pkg::SEL_W] = capture1_pin_sel_ff;
      rd_value[cips_pkg::HI_LSB +: cips_pkg::SEL_W] = capture2_pin_sel_ff;
    end
    else if (reg_hit[1])
    begin
      rd_value[cips_pkg::LO_LSB +: cips_pkg::SEL_W] = capture7_pin_sel_ff;
      rd_value[cips_pkg::HI_LSB +: cips_pkg::SEL_W] = capture8_pin_sel_ff;
    end
  end

  assign wr_sel12 = wr_commit && reg_hit[0];
  assign wr_sel78 = wr_commit && reg_hit[1];

  cips_avalon_slave u_bus (
    .mclk            (mclk),
    .rst_n           (rst_n),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .rd_value        (rd_value),
    .wr_commit       (wr_commit),
    .avs_waitrequest (avs_waitrequest),
    .avs_readdata    (avs_readdata)
  );

  // Capture 1 and 2 selects; lane 0 carries the low field, lane 1 the high one.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      capture1_pin_sel_ff <= cips_pkg::SEL_RST;
      capture2_pin_sel_ff <= cips_pkg::SEL_RST;
    end
    else if (wr_sel12)
    begin
      if (avs_byteenable[0])
      begin
        capture1_pin_sel_ff <= avs_writedata[cips_pkg::LO_LSB +: cips_pkg::SEL_W];
      end
      if (avs_byteenable[1])
      begin
        capture2_pin_sel_ff <= avs_writedata[cips_pkg::HI_LSB +: cips_pkg::SEL_W];
      end
    end
  end

  // Capture 7 and 8 selects; bits outside the fields are dropped, never stored.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      capture7_pin_sel_ff <= cips_pkg::SEL_RST;
      capture8_pin_sel_ff <= cips_pkg::SEL_RST;
    end
    else if (wr_sel78)
    begin
      if (avs_byteenable[0])
      begin
        capture7_pin_sel_ff <= avs_writedata[cips_pkg::LO_LSB +: cips_pkg::SEL_W];
      end
      if (avs_byteenable[1])
      begin
        capture8_pin_sel_ff <= avs_writedata[cips_pkg::HI_LSB +: cips_pkg::SEL_W];
      end
    end
  end

  // Four identical routes, one per capture input.
  cips_route_mux u_rt1 (
    .mclk           (mclk),
    .rst_n          (rst_n),
    .sel            (capture1_pin_sel_ff),
    .remappable_pin (remappable_pin),
    .capture_in     (capture_input_one)
  );

  cips_route_mux u_rt2 (
    .mclk           (mclk),
    .rst_n          (rst_n),
    .sel            (capture2_pin_sel_ff),
    .remappable_pin (remappable_pin),
    .capture_in     (capture_input_two)
  );

  cips_route_mux u_rt7 (
    .mclk           (mclk),
    .rst_n          (rst_n),
    .sel            (capture7_pin_sel_ff),
    .remappable_pin (remappable_pin),
    .capture_in     (capture_input_seven)
  );

  cips_route_mux u_rt8 (
    .mclk           (mclk),
    .rst_n          (rst_n),
    .sel            (capture8_pin_sel_ff),
    .remappable_pin (remappable_pin),
    .capture_in     (capture_input_eight)
  );

endmodule : cips_top

/* File: verif/cips_monitor.sv */
// Checker for the capture input pin select ports.
`timescale 1ns/1ps
module cips_monitor (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic [25:0] remappable_pin,
  input wire logic        capture_input_one
);
  logic [4:0] sel_ff;
  logic       rt;
  // Shadow of the capture one select, so routing is judged without looking inside.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      sel_ff <= 5'h1F;
    else if (avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable[0])
      sel_ff <= avs_writedata[4:0];
  end
  // Expected route; every code above the last pin gives low.
  assign rt = (sel_ff <= 5'h19) ? remappable_pin[sel_ff] : 1'b0;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_done; !avs_waitrequest ##1 avs_waitrequest; endsequence
  property p_ack; s_req |=> s_done; endproperty
  a_ack: assert property (p_ack) else $error("bus answer wrong");
  property p_rd;
    avs_read && !avs_waitrequest && avs_address == 4'h0 |-> avs_readdata[4:0] == sel_ff;
  endproperty
  a_rd: assert property (p_rd) else $error("select readback wrong");
  property p_zero; avs_read && !avs_waitrequest |-> (avs_readdata & 32'hFFFFE0E0) == 0; endproperty
  a_zero: assert property (p_zero) else $error("unused bits set");
  property p_route; capture_input_one == $past(rt); endproperty
  a_route: assert property (p_route) else $error("capture route wrong");
  property p_tie; sel_ff == 5'h1F |=> !capture_input_one; endproperty
  a_tie: assert property (p_tie) else $error("tied input not low");
endmodule : cips_monitor

bind cips_top cips_monitor u_mon (.mclk, .rst_n, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_waitrequest, .avs_readdata, .remappable_pin,
  .capture_input_one);

/* File: verif/cips_pin_model.sv */
// Remappable pin model: presents the levels that the bench asks for.
`timescale 1ns/1ps
module cips_pin_model (
  input  wire logic        mclk,
  input  wire logic [25:0] level,
  output logic      [25:0] remappable_pin
);
  // Pins move just after an edge, like any synchronous source.
  always_ff @(posedge mclk)
    remappable_pin <= level;
endmodule : cips_pin_model

/* File: verif/test_capture_input_pin_select.sv */
// Self-checking bench for the capture input pin select block.
`timescale 1ns/1ps
module test_capture_input_pin_select;
  logic        mclk = 0;
  logic        rst_n = 0;
  logic [3:0]  adr = 4'h0;
  logic        rd_en = 0;
  logic        wr_en = 0;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  be = 4'h0;
  logic        wait_req;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic [25:0] level = 26'h0;
  logic [25:0] pins;
  logic [3:0]  cap;
  int          errors = 0;
  int          samples_checked = 0;
  // Free running 100 MHz clock.
  always #5 mclk = ~mclk;
  cips_pin_model u_pins (.mclk, .level, .remappable_pin(pins));
  cips_top DUT (.mclk, .rst_n, .avs_address(adr), .avs_read(rd_en), .avs_write(wr_en),
    .avs_writedata(wdat), .avs_byteenable(be), .avs_waitrequest(wait_req),
    .avs_readdata(rdat), .remappable_pin(pins), .capture_input_one(cap[0]),
    .capture_input_two(cap[1]), .capture_input_seven(cap[2]), .capture_input_eight(cap[3]));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // One transfer, held until waitrequest is seen low; a stuck slave ends the run.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    int n;
    adr <= a;
    wr_en <= w;
    rd_en <= !w;
    wdat <= d;
    be <= b;
    for (n = 0; n < 20; n++)
    begin
      @(posedge mclk);
      if (wait_req === 1'b0)
        break;
    end
    rd = rdat;
    if (n == 20)
    begin
      errors++;
      complete_run;
    end
    wr_en <= 0;
    rd_en <= 0;
    @(posedge mclk);
  endtask : bus
  task automatic t_reset;
    chk({28'h0, cap}, 0);
    bus(0, 4'h0, 0, 4'hF);
    chk(rd, 32'h1F1F);
    bus(0, 4'h4, 0, 4'hF);
    chk(rd, 32'h1F1F);
    $display("reset test done");
  endtask : t_reset
  // Unused bits, a single lane and an unmapped offset.
  task automatic t_fields;
    bus(1, 4'h0, 32'hFFFFE0E0, 4'hF);
    bus(0, 4'h0, 0, 4'hF);
    chk(rd, 0);
    bus(1, 4'h0, 32'h1919, 4'h2);
    bus(0, 4'h0, 0, 4'hF);
    chk(rd, 32'h1900);
    bus(1, 4'h8, 32'h1919, 4'hF);
    bus(0, 4'h8, 0, 4'hF);
    chk(rd, 0);
    $display("field test done");
  endtask : t_fields
  // Every code: pins 0 to 25, then the unused codes and the tie code, which all give low.
  // Capture eight uses the mirrored code.
  task automatic t_route;
    logic [4:0]  k;
    logic [4:0]  j;
    logic [25:0] p;
    logic        ok;
    for (int c = 0; c < 32; c++)
    begin
      k = 5'(c);
      ok = k <= 5'h19;
      j = ok ? 5'h19 - k : k;
      p = ok ? 26'h1 << k : 26'h3FFFFFF;
      bus(1, 4'h0, {19'h0, k, 3'h0, k}, 4'h3);
      bus(1, 4'h4, {19'h0, j, 3'h0, k}, 4'h3);
      bus(0, 4'h4, 0, 4'hF);
      chk(rd, {19'h0, j, 3'h0, k});
      level <= p;
      repeat (3) @(posedge mclk);
      chk({28'h0, cap}, ok ? 7 : 0);
      level <= ~p;
      repeat (3) @(posedge mclk);
      chk({28'h0, cap}, ok ? 8 : 0);
    end
    $display("route test done");
  endtask : t_route
  // Reset in mid-run: a select that was moved away from its reset value must return to it.
  task automatic t_rerst;
    bus(1, 4'h0, 32'h0505, 4'h3);
    level <= 26'h3FFFFFF;
    repeat (3) @(posedge mclk);
    chk({28'h0, cap}, 3);
    rst_n <= 0;
    repeat (2) @(posedge mclk);
    rst_n <= 1;
    @(posedge mclk);
    chk({28'h0, cap}, 0);
    bus(0, 4'h0, 0, 4'hF);
    chk(rd, 32'h1F1F);
    $display("mid-run reset test done");
  endtask : t_rerst
  // Main sequence.
  initial
  begin
    repeat (8) @(posedge mclk);
    rst_n <= 1;
    @(posedge mclk);
    t_reset;
    t_fields;
    t_route;
    t_rerst;
    complete_run;
  end
endmodule : test_capture_input_pin_select
